// ### core/tss_top.v
// Purpose: Set-up supervisor: panel edits, protection, standby, station ID.
// Assumes: RF measurements and panel keys are synchronous to core_clk.
// Notes: Registers sit on an Avalon-MM slave with one wait cycle per access.
// Functional notes
// - Low forward power in operate: shutdown, hold.
// - After hold, re-enable, re-measure, maybe repeat.
// - Reflected above maximum: fold forward power down.
// - Reflected five percent over: shutdown, hold.
// - After reflected hold, re-enable and re-check.
// - Condition cleared: power climbs back automatically.
// - Modulation fault over ten seconds: auto standby.
// - Modulation fault clears: operate resumes.
// - Station ID triggered every fifteen minutes.
// - All-blank identifier disables station ID.
// - Serial address settable, defaults to five.
// - Calibration 0..255 shown on 40-pixel bar.
// - Changed value asks confirmation on next.
// - Accept needs both accept keys together.
// - Return needs both return keys together.
// - Plus raises the shown power or channel, minus lowers it.
// - Channel change goes straight to synthesizer.
// - Remote disabled: ignore terminal and serial commands.
// - Exit key leaves set-up to access screen.
// - Set-up values kept in non-volatile storage.
`timescale 1ns/100ps
`default_nettype none
`include "tss_defs.vh"
module tss_top #(
  parameter integer PRESCALE = `TSS_TICK_US * `TSS_CLK_MHZ,
  parameter integer DB_CYC = `TSS_DEBOUNCE_CYC,
  parameter integer SETTLE_CYC = `TSS_SETTLE_CYC
) (
  input wire core_clk,
  input wire nrst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire key_plus,
  input wire key_minus,
  input wire key_next,
  input wire exit_key,
  input wire enter_key,
  input wire key_accept_a,
  input wire key_accept_b,
  input wire key_return_a,
  input wire key_return_b,
  input wire rem_operate,
  input wire rem_standby,
  input wire ser_cmd_valid,
  input wire ser_cmd_operate,
  input wire [7:0] fwd_pwr,
  input wire [7:0] rfl_pwr,
  input wire mod_fault,
  output reg tx_enable,
  output reg [7:0] power_drive,
  output reg [7:0] synth_chan,
  output reg synth_load,
  output reg sid_trigger,
  output reg nv_write,
  output reg in_setup,
  output reg confirm_prompt,
  output reg fault_fwd,
  output reg fault_rfl,
  output reg auto_standby
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] UI_IDLE = 3'b001;
  localparam [2:0] UI_EDIT = 3'b010;
  localparam [2:0] UI_CONF = 3'b100;
  localparam [2:0] PR_RUN = 3'b001;
  localparam [2:0] PR_HOLD = 3'b010;
  localparam [2:0] PR_SETTLE = 3'b100;
  localparam integer NKEY = 9;

  reg [2:0] ui_reg;
  reg [2:0] pr_reg;
  reg [2:0] ctrl_reg;
  reg [7:0] fwd_min_reg;
  reg [7:0] rfl_max_reg;
  reg [7:0] ser_addr_reg;
  reg [31:0] sid_lo_reg;
  reg [7:0] sid_hi_reg;
  reg [7:0] cal_reg [0:3];
  reg [7:0] chan_reg;
  reg [7:0] power_reg;
  reg [7:0] shadow_reg;
  reg screen_reg;
  reg dirty_reg;
  reg [7:0] fold_reg;
  reg [7:0] settle_reg;
  reg [31:0] pre_reg;
  reg tick_reg;
  reg [NKEY-1:0] key_prev_reg;
  wire [NKEY-1:0] key_raw;
  wire [NKEY-1:0] key_db;
  wire [NKEY-1:0] key_rise;
  wire mod_done;
  wire hold_done;
  wire sid_done;
  wire sid_on;
  wire op_eff;
  wire rfl_over;
  wire rfl_trip;
  wire fwd_low;
  wire accept_hit;
  wire return_hit;
  wire bus_wr;
  reg [31:0] rd_next;
  reg [13:0] bar_prod;
  reg [7:0] cal_sel;
  integer i;

  // ----------------------------------------
  // Key conditioning
  // ----------------------------------------
  assign key_raw = {key_return_b, key_return_a, key_accept_b, key_accept_a,
                    enter_key, exit_key, key_next, key_minus, key_plus};

  genvar g;
  generate
    for (g = 0; g < NKEY; g = g + 1) begin : g_key
      tss_debounce #(.DB_CYC(DB_CYC)) u_db (
        .core_clk(core_clk),
        .nrst(nrst),
        .key_raw(key_raw[g]),
        .key_stable(key_db[g])
      );
    end
  endgenerate

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      key_prev_reg <= {NKEY{1'b0}};
    end else begin
      key_prev_reg <= key_db;
    end
  end
  assign key_rise = key_db & ~key_prev_reg;
  // A pair acts once, when the second key of it settles while the first is held.
  assign accept_hit = key_db[5] & key_db[6] & (key_rise[5] | key_rise[6]);
  assign return_hit = key_db[7] & key_db[8] & (key_rise[7] | key_rise[8]);

  // ----------------------------------------
  // Prescaler and interval timers
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (pre_reg >= PRESCALE - 1) begin
      pre_reg <= 32'h0;
      tick_reg <= 1'b1;
    end else begin
      pre_reg <= pre_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  tss_interval #(.LIMIT(`TSS_MODLOSS_TICKS)) u_mod_tmr (
    .core_clk(core_clk),
    .nrst(nrst),
    .en(mod_fault & ctrl_reg[`TSS_CTRL_AUTO_STBY] & ~auto_standby),
    .tick(tick_reg),
    .done(mod_done)
  );

  tss_interval #(.LIMIT(`TSS_FAULT_HOLD_TICKS)) u_hold_tmr (
    .core_clk(core_clk),
    .nrst(nrst),
    .en(pr_reg == PR_HOLD),
    .tick(tick_reg),
    .done(hold_done)
  );

  tss_interval #(.LIMIT(`TSS_SID_PERIOD_TICKS)) u_sid_tmr (
    .core_clk(core_clk),
    .nrst(nrst),
    .en(sid_on),
    .tick(tick_reg),
    .done(sid_done)
  );

  assign sid_on = ~((sid_lo_reg == {4{`TSS_BLANK_CHAR}}) &&
                    (sid_hi_reg == `TSS_BLANK_CHAR));

  // ----------------------------------------
  // Protection
  // ----------------------------------------
  assign op_eff = ctrl_reg[`TSS_CTRL_OPERATE] & ~auto_standby;
  assign fwd_low = (fwd_pwr <= fwd_min_reg);
  assign rfl_over = (rfl_pwr > rfl_max_reg);
  // Five percent over the limit, done as 20*rfl >= 21*max to avoid a divider.
  assign rfl_trip = ({5'h0, rfl_pwr} * 13'd20) >= ({5'h0, rfl_max_reg} * 13'd21);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pr_reg <= PR_RUN;
      settle_reg <= 8'h0;
      fold_reg <= 8'h0;
      fault_fwd <= 1'b0;
      fault_rfl <= 1'b0;
      tx_enable <= 1'b0;
      power_drive <= 8'h0;
      auto_standby <= 1'b0;
      sid_trigger <= 1'b0;
    end else begin
      if (mod_done) begin
        auto_standby <= 1'b1;
      end else if (!mod_fault) begin
        auto_standby <= 1'b0;
      end
      sid_trigger <= sid_done & sid_on;
      case (pr_reg)
        PR_RUN: begin
          tx_enable <= op_eff;
          // The detector reads zero until the output is on, so judge it only then.
          if (op_eff && tx_enable && fwd_low) begin
            pr_reg <= PR_HOLD;
            fault_fwd <= 1'b1;
            tx_enable <= 1'b0;
          end else if (op_eff && rfl_trip) begin
            pr_reg <= PR_HOLD;
            fault_rfl <= 1'b1;
            tx_enable <= 1'b0;
          end else if (tick_reg && rfl_over && fold_reg != power_reg) begin
            fold_reg <= fold_reg + 8'h1;
          end else if (tick_reg && !rfl_over && fold_reg != 8'h0) begin
            fold_reg <= fold_reg - 8'h1;
          end
        end
        PR_HOLD: begin
          tx_enable <= 1'b0;
          if (hold_done) begin
            pr_reg <= PR_SETTLE;
            settle_reg <= 8'h0;
            tx_enable <= 1'b1;
          end
        end
        PR_SETTLE: begin
          // The detectors need a moment after re-enable before they are trusted.
          tx_enable <= 1'b1;
          if (settle_reg >= SETTLE_CYC[7:0] - 8'h1) begin
            if (fwd_low) begin
              pr_reg <= PR_HOLD;
              fault_fwd <= 1'b1;
              tx_enable <= 1'b0;
            end else if (rfl_trip) begin
              pr_reg <= PR_HOLD;
              fault_rfl <= 1'b1;
              tx_enable <= 1'b0;
            end else begin
              pr_reg <= PR_RUN;
              fault_fwd <= 1'b0;
              fault_rfl <= 1'b0;
            end
          end else begin
            settle_reg <= settle_reg + 8'h1;
          end
        end
        default: begin
          pr_reg <= PR_RUN;
        end
      endcase
      power_drive <= (fold_reg > power_reg) ? 8'h0 : power_reg - fold_reg;
    end
  end

  // ----------------------------------------
  // Register read mux and calibration bar
  // ----------------------------------------
  always @* begin
    cal_sel = cal_reg[address[3:2] - 2'h2];
    bar_prod = ({6'h0, cal_sel} * 14'd40) / 14'd255;
    rd_next = 32'h0;
    case (address)
      `TSS_OFS_CTRL: rd_next = {29'h0, ctrl_reg};
      `TSS_OFS_FWD_MIN: rd_next = {24'h0, fwd_min_reg};
      `TSS_OFS_RFL_MAX: rd_next = {24'h0, rfl_max_reg};
      `TSS_OFS_SER_ADDR: rd_next = {24'h0, ser_addr_reg};
      `TSS_OFS_SID_LO: rd_next = sid_lo_reg;
      `TSS_OFS_SID_HI: rd_next = {24'h0, sid_hi_reg};
      `TSS_OFS_CHAN: rd_next = {24'h0, chan_reg};
      `TSS_OFS_POWER: rd_next = {24'h0, power_reg};
      `TSS_OFS_STATUS: rd_next = {16'h0, fold_reg, sid_on, pr_reg, dirty_reg,
                                 auto_standby, fault_rfl, fault_fwd};
      default: begin
        if (address >= `TSS_OFS_CAL0 && address <= `TSS_OFS_CAL3 &&
            address[1:0] == 2'h0) begin
          rd_next = {10'h0, bar_prod[5:0], 8'h0, cal_sel};
        end
      end
    endcase
  end

  // ----------------------------------------
  // Bus slave, panel state machine and set-up registers
  // ----------------------------------------
  assign bus_wr = write & ~waitrequest;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      ui_reg <= UI_IDLE;
      ctrl_reg <= `TSS_CTRL_RST;
      fwd_min_reg <= `TSS_FWD_MIN_RST;
      rfl_max_reg <= `TSS_RFL_MAX_RST;
      ser_addr_reg <= `TSS_SER_ADDR_RST;
      sid_lo_reg <= {4{`TSS_BLANK_CHAR}};
      sid_hi_reg <= `TSS_BLANK_CHAR;
      for (i = 0; i < 4; i = i + 1) begin
        cal_reg[i] <= 8'h80;
      end
      chan_reg <= `TSS_CHAN_RST;
      power_reg <= `TSS_POWER_RST;
      shadow_reg <= 8'h0;
      screen_reg <= 1'b0;
      dirty_reg <= 1'b0;
      synth_chan <= `TSS_CHAN_RST;
      synth_load <= 1'b0;
      nv_write <= 1'b0;
      in_setup <= 1'b0;
      confirm_prompt <= 1'b0;
    end else begin
      synth_load <= 1'b0;
      nv_write <= 1'b0;
      // One wait cycle: data is fetched now and stands when waitrequest drops.
      if ((read | write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata <= rd_next;
      end else begin
        waitrequest <= 1'b1;
      end
      if (bus_wr) begin
        nv_write <= 1'b1;
        case (address)
          `TSS_OFS_CTRL: ctrl_reg <= writedata[2:0];
          `TSS_OFS_FWD_MIN: fwd_min_reg <= writedata[7:0];
          `TSS_OFS_RFL_MAX: rfl_max_reg <= writedata[7:0];
          `TSS_OFS_SER_ADDR: ser_addr_reg <= writedata[7:0];
          `TSS_OFS_SID_LO: sid_lo_reg <= writedata;
          `TSS_OFS_SID_HI: sid_hi_reg <= writedata[7:0];
          `TSS_OFS_CHAN: begin
            chan_reg <= writedata[7:0];
            synth_chan <= writedata[7:0];
            synth_load <= 1'b1;
          end
          `TSS_OFS_POWER: power_reg <= writedata[7:0];
          default: begin
            if (address >= `TSS_OFS_CAL0 && address <= `TSS_OFS_CAL3 &&
                address[1:0] == 2'h0) begin
              cal_reg[address[3:2] - 2'h2] <= writedata[7:0];
            end else begin
              nv_write <= 1'b0;
            end
          end
        endcase
      end else if (ctrl_reg[`TSS_CTRL_REMOTE] && (rem_operate || rem_standby)) begin
        ctrl_reg[`TSS_CTRL_OPERATE] <= rem_operate;
      end else if (ctrl_reg[`TSS_CTRL_REMOTE] && ser_cmd_valid) begin
        ctrl_reg[`TSS_CTRL_OPERATE] <= ser_cmd_operate;
      end
      case (ui_reg)
        UI_IDLE: begin
          in_setup <= 1'b0;
          confirm_prompt <= 1'b0;
          if (key_rise[4]) begin
            ui_reg <= UI_EDIT;
            in_setup <= 1'b1;
            screen_reg <= 1'b0;
            shadow_reg <= power_reg;
            dirty_reg <= 1'b0;
          end
        end
        UI_EDIT: begin
          if (key_rise[3]) begin
            ui_reg <= UI_IDLE;
            in_setup <= 1'b0;
            dirty_reg <= 1'b0;
            if (dirty_reg && screen_reg) begin
              synth_chan <= chan_reg;
              synth_load <= 1'b1;
            end
          end else if (key_rise[0] && shadow_reg != 8'hff) begin
            shadow_reg <= shadow_reg + 8'h1;
            dirty_reg <= 1'b1;
            if (screen_reg) begin
              synth_chan <= shadow_reg + 8'h1;
              synth_load <= 1'b1;
            end
          end else if (key_rise[1] && shadow_reg != 8'h0) begin
            shadow_reg <= shadow_reg - 8'h1;
            dirty_reg <= 1'b1;
            if (screen_reg) begin
              synth_chan <= shadow_reg - 8'h1;
              synth_load <= 1'b1;
            end
          end else if (key_rise[2]) begin
            if (dirty_reg) begin
              ui_reg <= UI_CONF;
              confirm_prompt <= 1'b1;
            end else begin
              screen_reg <= ~screen_reg;
              shadow_reg <= screen_reg ? power_reg : chan_reg;
            end
          end
        end
        UI_CONF: begin
          if (accept_hit) begin
            ui_reg <= UI_EDIT;
            confirm_prompt <= 1'b0;
            dirty_reg <= 1'b0;
            nv_write <= 1'b1;
            if (screen_reg) begin
              chan_reg <= shadow_reg;
            end else begin
              power_reg <= shadow_reg;
            end
            screen_reg <= ~screen_reg;
            shadow_reg <= screen_reg ? power_reg : chan_reg;
          end else if (return_hit) begin
            ui_reg <= UI_EDIT;
            confirm_prompt <= 1'b0;
            dirty_reg <= 1'b0;
            shadow_reg <= screen_reg ? chan_reg : power_reg;
            if (screen_reg) begin
              synth_chan <= chan_reg;
              synth_load <= 1'b1;
            end
          end
        end
        default: begin
          ui_reg <= UI_IDLE;
        end
      endcase
    end
  end
endmodule // tss_top
`default_nettype wire

// ### core/tss_defs.vh
// Purpose: Shared constants of the transmitter set-up supervisor.
// Assumes: Included by bare name from the tss_top module only.
// Notes: Times are kept in their own unit; cycle counts other than TSS_SETTLE_CYC derive from them.
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TSS_OFS_CTRL 8'h00
`define TSS_OFS_FWD_MIN 8'h04
`define TSS_OFS_RFL_MAX 8'h08
`define TSS_OFS_SER_ADDR 8'h0c
`define TSS_OFS_SID_LO 8'h10
`define TSS_OFS_SID_HI 8'h14
`define TSS_OFS_CAL0 8'h18
`define TSS_OFS_CAL3 8'h24
`define TSS_OFS_CHAN 8'h28
`define TSS_OFS_POWER 8'h2c
`define TSS_OFS_STATUS 8'h30
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define TSS_CTRL_OPERATE 0
`define TSS_CTRL_AUTO_STBY 1
`define TSS_CTRL_REMOTE 2
`define TSS_CTRL_RST 3'h5
`define TSS_SER_ADDR_RST 8'h05
`define TSS_FWD_MIN_RST 8'h20
`define TSS_RFL_MAX_RST 8'h20
`define TSS_POWER_RST 8'hff
`define TSS_CHAN_RST 8'h02
`define TSS_BLANK_CHAR 8'h20
`define TSS_CAL_FULL 255
`define TSS_BAR_PIXELS 40
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSS_CLK_MHZ 10
`define TSS_TICK_US 100000
`define TSS_MODLOSS_MS 10000
`define TSS_FAULT_HOLD_MS 300000
`define TSS_SID_PERIOD_MS 900000
`define TSS_MODLOSS_TICKS (`TSS_MODLOSS_MS * 1000 / `TSS_TICK_US)
`define TSS_FAULT_HOLD_TICKS (`TSS_FAULT_HOLD_MS * 1000 / `TSS_TICK_US)
`define TSS_SID_PERIOD_TICKS (`TSS_SID_PERIOD_MS * 1000 / `TSS_TICK_US)
`define TSS_DEBOUNCE_US 2000
`define TSS_DEBOUNCE_CYC (`TSS_DEBOUNCE_US * `TSS_CLK_MHZ)
`define TSS_SETTLE_CYC 16
`endif

// ### core/tss_debounce.v
// Purpose: Debounces one front-panel key.
// Assumes: Key level is synchronous to core_clk.
// Notes: The output changes only after the input held steady for DB_CYC cycles.
`timescale 1ns/100ps
`default_nettype none
module tss_debounce #(
  parameter integer DB_CYC = 20000
) (
  input wire core_clk,
  input wire nrst,
  input wire key_raw,
  output reg key_stable
);
  reg [31:0] cnt_reg;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0;
      key_stable <= 1'b0;
    end else if (key_raw == key_stable) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg >= DB_CYC - 1) begin
      cnt_reg <= 32'h0;
      key_stable <= key_raw;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule // tss_debounce
`default_nettype wire

// ### core/tss_interval.v
// Purpose: Counts prescaler ticks while enabled and pulses at the limit.
// Assumes: tick is a one-cycle pulse from the shared prescaler.
// Notes: Dropping en clears the count, so a broken condition restarts timing.
`timescale 1ns/100ps
`default_nettype none
module tss_interval #(
  parameter integer LIMIT = 100
) (
  input wire core_clk,
  input wire nrst,
  input wire en,
  input wire tick,
  output reg done
);
  reg [15:0] cnt_reg;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 16'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!en) begin
        cnt_reg <= 16'h0;
      end else if (tick) begin
        if (cnt_reg == LIMIT[15:0] - 16'h1) begin
          cnt_reg <= 16'h0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h1;
        end
      end
    end
  end
endmodule // tss_interval
`default_nettype wire

// ### sim/tss_top_assertions.sv
// Purpose: Port-level timing checks for the set-up supervisor.
// Assumes: Threshold registers keep reset values; PRESCALE is 4.
// Notes: Hold and standby windows allow 10 to 20 cycles of phase slack.
`timescale 1ns/100ps
`default_nettype none
module tss_top_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [7:0] fwd_pwr,
  input wire logic [7:0] rfl_pwr,
  input wire logic mod_fault,
  input wire logic tx_enable,
  input wire logic [7:0] synth_chan,
  input wire logic synth_load,
  input wire logic sid_trigger,
  input wire logic nv_write,
  input wire logic fault_fwd,
  input wire logic fault_rfl,
  input wire logic auto_standby
);
  logic [15:0] hold_cnt;
  logic [9:0] mod_cnt;
  // ----
  // Counters for windows too long to unroll
  // ----
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 16'h0;
      mod_cnt <= 10'h0;
    end else begin
      hold_cnt <= tx_enable ? 16'h0 : ((fault_fwd | fault_rfl) ? hold_cnt + 16'h1 : hold_cnt);
      mod_cnt <= !mod_fault ? 10'h0 : ((mod_cnt == 10'h3ff) ? mod_cnt : mod_cnt + 10'h1);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_fwd_low;
    (tx_enable && fwd_pwr <= 8'h20) [*8];
  endsequence
  sequence s_rfl_high;
    (tx_enable && 20 * rfl_pwr >= 672) [*8];
  endsequence
  sequence s_ser_write;
    write && !waitrequest && address == 8'h0c;
  endsequence
  a_fwd_low_trip: assert property (s_fwd_low |-> ##[0:20] fault_fwd)
    else $error("forward power low without fault");
  a_hold_max: assert property (hold_cnt <= 16'd12020)
    else $error("fault hold too long");
  a_hold_min: assert property ($rose(tx_enable) && hold_cnt != 16'h0 |-> hold_cnt >= 16'd11990)
    else $error("output back before hold ended");
  a_rfl_trip: assert property (s_rfl_high |-> ##[0:20] fault_rfl)
    else $error("reflected overload without fault");
  a_fold_no_trip: assert property ($rose(fault_rfl) |-> 20 * $past(rfl_pwr) >= 672)
    else $error("reflected fault below trip level");
  a_stby_late: assert property ($rose(auto_standby) |-> mod_cnt >= 10'd390)
    else $error("standby entered too early");
  a_stby_off: assert property (auto_standby && $past(auto_standby) |-> !tx_enable)
    else $error("output on in standby");
  a_stby_clear: assert property ($fell(mod_fault) |-> ##[1:3] !auto_standby)
    else $error("standby kept after fault cleared");
  a_synth_load: assert property ($changed(synth_chan) |-> ##[0:1] synth_load)
    else $error("channel change not loaded");
  a_nv_store: assert property (s_ser_write |-> ##[1:2] nv_write)
    else $error("set-up write not stored");
  a_sid_pulse: assert property (sid_trigger |=> !sid_trigger)
    else $error("station id pulse too long");
endmodule // tss_top_assertions
bind tss_top tss_top_assertions tss_top_assertions_i (.core_clk(core_clk), .nrst(nrst),
  .address(address), .write(write), .waitrequest(waitrequest), .fwd_pwr(fwd_pwr),
  .rfl_pwr(rfl_pwr), .mod_fault(mod_fault), .tx_enable(tx_enable), .synth_chan(synth_chan),
  .synth_load(synth_load), .sid_trigger(sid_trigger), .nv_write(nv_write),
  .fault_fwd(fault_fwd), .fault_rfl(fault_rfl), .auto_standby(auto_standby));
`default_nettype wire

// ### sim/tss_rf_model.sv
// Purpose: RF chain stand-in with forward and reflected detectors.
// Assumes: Detectors read zero while the carrier is off.
// Notes: fwd_lost fakes a dead amplifier, rfl_level a bad load.
`timescale 1ns/100ps
`default_nettype none
module tss_rf_model (
  input wire logic tx_enable,
  input wire logic [7:0] power_drive,
  input wire logic fwd_lost,
  input wire logic [7:0] rfl_level,
  output logic [7:0] fwd_pwr,
  output logic [7:0] rfl_pwr
);
  assign fwd_pwr = (tx_enable && !fwd_lost) ? power_drive : 8'h00;
  assign rfl_pwr = tx_enable ? rfl_level : 8'h00;
endmodule // tss_rf_model
`default_nettype wire

// ### sim/tss_top_tb.sv
// Purpose: Self-checking bench for the set-up supervisor.
// Assumes: PRESCALE 4 and DB_CYC 2 shorten ticks and debounce.
// Notes: Fault holds are waited out in full, so the run is long.
`timescale 1ns/100ps
`default_nettype none
module tss_top_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [8:0] keys = 9'h000;
  logic [3:0] rem = 4'h0;
  logic mod_fault = 1'b0;
  logic fwd_lost = 1'b0;
  logic [7:0] rfl_level = 8'h00;
  logic [31:0] readdata, q;
  logic [7:0] fwd_pwr, rfl_pwr, power_drive, synth_chan;
  logic waitrequest, tx_enable, synth_load, sid_trigger, nv_write, in_setup;
  logic confirm_prompt, fault_fwd, fault_rfl, auto_standby, tx_q;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises = 0;
  int sids = 0;
  tss_top #(.PRESCALE(4), .DB_CYC(2), .SETTLE_CYC(16)) tss_top_i (.core_clk(core_clk),
    .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .key_plus(keys[0]), .key_minus(keys[1]),
    .key_next(keys[2]), .exit_key(keys[3]), .enter_key(keys[4]), .key_accept_a(keys[5]),
    .key_accept_b(keys[6]), .key_return_a(keys[7]), .key_return_b(keys[8]),
    .rem_operate(rem[0]), .rem_standby(rem[1]), .ser_cmd_valid(rem[2]),
    .ser_cmd_operate(rem[3]), .fwd_pwr(fwd_pwr), .rfl_pwr(rfl_pwr), .mod_fault(mod_fault),
    .tx_enable(tx_enable), .power_drive(power_drive), .synth_chan(synth_chan),
    .synth_load(synth_load), .sid_trigger(sid_trigger), .nv_write(nv_write),
    .in_setup(in_setup), .confirm_prompt(confirm_prompt), .fault_fwd(fault_fwd),
    .fault_rfl(fault_rfl), .auto_standby(auto_standby));
  tss_rf_model tss_rf_model_i (.tx_enable(tx_enable), .power_drive(power_drive),
    .fwd_lost(fwd_lost), .rfl_level(rfl_level), .fwd_pwr(fwd_pwr), .rfl_pwr(rfl_pwr));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ----
  // Monitors and hang guard
  // ----
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    tx_q <= tx_enable;
    if (tx_enable === 1'b1 && tx_q === 1'b0) rises <= rises + 1;
    if (sid_trigger === 1'b1) sids <= sids + 1;
    if (cyc == 95000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Holds the request until waitrequest is seen low, then lets one edge pass.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic press(input logic [8:0] m);
    keys <= m;
    cyc_wait(6);
    keys <= 9'h000;
    cyc_wait(6);
  endtask
  task automatic remote(input logic [3:0] m);
    rem <= m;
    cyc_wait(2);
    rem <= 4'h0;
    cyc_wait(4);
  endtask
  task automatic t_regs;
    int i;
    int n;
    logic [7:0] a;
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h5);
    bus(1'b1, 8'h0c, 32'h9);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h9);
    bus(1'b1, 8'h34, 32'hff);
    bus(1'b0, 8'h34, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0014_0080);
    for (i = 0; i < 4; i++) begin
      n = 255 - 85 * i;
      a = 8'(24 + 4 * i);
      bus(1'b1, a, 32'(n));
      bus(1'b0, a, 32'h0);
      chk(q, 32'(((n * 40 / 255) << 16) | n));
    end
  endtask
  task automatic t_chan;
    bus(1'b1, 8'h28, 32'h7);
    cyc_wait(2);
    chk(synth_chan, 32'h7);
  endtask
  task automatic t_keys;
    press(9'h010);
    chk(in_setup, 1);
    press(9'h001);
    press(9'h002);
    press(9'h004);
    chk(confirm_prompt, 1);
    press(9'h020);
    chk(confirm_prompt, 1);
    press(9'h060);
    chk(confirm_prompt, 0);
    chk(power_drive, 32'hfe);
    bus(1'b0, 8'h2c, 32'h0);
    chk(q, 32'hfe);
    press(9'h001);
    chk(synth_chan, 32'h8);
    press(9'h004);
    press(9'h180);
    chk(confirm_prompt, 0);
    chk(synth_chan, 32'h7);
    press(9'h008);
    chk(in_setup, 0);
  endtask
  task automatic t_remote;
    bus(1'b1, 8'h00, 32'h1);
    remote(4'h2);
    remote(4'h4);
    chk(tx_enable, 1);
    bus(1'b1, 8'h00, 32'h5);
    remote(4'h2);
    chk(tx_enable, 0);
    remote(4'hc);
    chk(tx_enable, 1);
    remote(4'h4);
    chk(tx_enable, 0);
    remote(4'h1);
    chk(tx_enable, 1);
  endtask
  task automatic t_stby;
    bus(1'b1, 8'h00, 32'h7);
    mod_fault <= 1'b1;
    cyc_wait(380);
    chk(auto_standby, 0);
    cyc_wait(40);
    chk(auto_standby, 1);
    chk(tx_enable, 0);
    mod_fault <= 1'b0;
    cyc_wait(5);
    chk(tx_enable, 1);
  endtask
  task automatic t_fold;
    rfl_level <= 8'h21;
    cyc_wait(200);
    chk(power_drive < 8'hfe, 1);
    chk(fault_rfl, 0);
    rfl_level <= 8'h10;
    cyc_wait(300);
    chk(power_drive, 32'hfe);
  endtask
  task automatic t_rfl;
    int r0;
    r0 = rises;
    rfl_level <= 8'h22;
    cyc_wait(20);
    chk(fault_rfl, 1);
    chk(tx_enable, 0);
    cyc_wait(12100);
    chk(rises - r0, 1);
    chk(fault_rfl, 1);
    rfl_level <= 8'h00;
    cyc_wait(12100);
    chk(tx_enable, 1);
    chk(fault_rfl, 0);
  endtask
  task automatic t_fwd;
    int r0;
    r0 = rises;
    fwd_lost <= 1'b1;
    cyc_wait(20);
    chk(fault_fwd, 1);
    chk(tx_enable, 0);
    cyc_wait(12100);
    chk(rises - r0, 1);
    chk(fault_fwd, 1);
    fwd_lost <= 1'b0;
    cyc_wait(12100);
    chk(tx_enable, 1);
  endtask
  task automatic t_sid;
    chk(sids, 0);
    bus(1'b1, 8'h10, 32'h4142_4344);
    cyc_wait(36100);
    chk(sids, 1);
  endtask
  initial begin
    cyc_wait(12);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_chan;
    t_keys;
    t_remote;
    t_stby;
    t_fold;
    t_rfl;
    t_fwd;
    t_sid;
    complete_run;
  end
endmodule // tss_top_tb
`default_nettype wire
